// >>> design/ofd_cfg.svh
// Field codes, widths and reset values for the operand field decoder.
`ifndef OFD_CFG_SVH
`define OFD_CFG_SVH

// Addressing-form field codes.
`define OFD_MOD_NODISP   2'h0
`define OFD_MOD_DISP8    2'h1
`define OFD_MOD_DISP16   2'h2
`define OFD_MOD_REGISTER 2'h3

// Memory-operand field codes.
`define OFD_MEM_BW_SI    3'h0
`define OFD_MEM_BW_DI    3'h1
`define OFD_MEM_BP_SI    3'h2
`define OFD_MEM_BP_DI    3'h3
`define OFD_MEM_SI       3'h4
`define OFD_MEM_DI       3'h5
`define OFD_MEM_DIRECT   3'h6
`define OFD_MEM_BW       3'h7

// Sign-extend and size pair codes that call for a word immediate.
`define OFD_SW_WORD_A    2'h1
`define OFD_SW_WORD_B    2'h3

// Byte counts reported for displacement and immediate data.
`define OFD_BYTES_NONE   2'h0
`define OFD_BYTES_ONE    2'h1
`define OFD_BYTES_TWO    2'h2

// Position of the sign bit in a byte offset.
`define OFD_BYTE_SIGN    7

// Reset values of the registered outputs.
`define OFD_RST_WORD     16'h0000
`define OFD_RST_BYTES    2'h0
`define OFD_RST_SEG      2'h3

`endif

// >>> design/ofd_pkg.sv
// Types shared by the operand field decoder modules.
package ofd_pkg;

    typedef enum logic [3:0] {
        OFD_ACCUMULATOR_LOW   = 4'h0,
        OFD_COUNT_LOW         = 4'h1,
        OFD_DATA_LOW          = 4'h2,
        OFD_BASE_LOW          = 4'h3,
        OFD_ACCUMULATOR_HIGH  = 4'h4,
        OFD_COUNT_HIGH        = 4'h5,
        OFD_DATA_HIGH         = 4'h6,
        OFD_BASE_HIGH         = 4'h7,
        OFD_ACCUMULATOR_WORD  = 4'h8,
        OFD_COUNT_WORD        = 4'h9,
        OFD_DATA_WORD         = 4'ha,
        OFD_BASE_WORD         = 4'hb,
        OFD_STACK_POINTER     = 4'hc,
        OFD_BASE_POINTER      = 4'hd,
        OFD_SOURCE_INDEX      = 4'he,
        OFD_DESTINATION_INDEX = 4'hf
    } ofd_reg_e;

    typedef enum logic [1:0] {
        OFD_DATA_SEGMENT_ONE  = 2'h0,
        OFD_PROGRAM_SEGMENT   = 2'h1,
        OFD_STACK_SEGMENT     = 2'h2,
        OFD_DATA_SEGMENT_ZERO = 2'h3
    } ofd_seg_e;

    typedef logic [15:0] ofd_word_t;

endpackage

// >>> design/ofd_disp_ext.sv
// Displacement sizing and sign extension for the operand field decoder.
`timescale 1ns/1ps
`default_nettype none
`include "ofd_cfg.svh"

module ofd_disp_ext
    import ofd_pkg::*;
(
    input  wire logic [1:0] mode_field,
    input  wire logic       direct,
    input  wire logic [7:0] disp_lo,
    input  wire logic [7:0] disp_hi,
    output ofd_word_t       disp_word,
    output logic [1:0]      disp_bytes
);

    always_comb begin
        disp_word  = `OFD_RST_WORD;
        disp_bytes = `OFD_BYTES_NONE;
        if (direct) begin
            // A direct address always carries a full word.
            disp_word  = {disp_hi, disp_lo};
            disp_bytes = `OFD_BYTES_TWO;
        end else begin
            case (mode_field)
                `OFD_MOD_DISP8: begin
                    disp_word  = {{8{disp_lo[`OFD_BYTE_SIGN]}}, disp_lo};
                    disp_bytes = `OFD_BYTES_ONE;
                end
                `OFD_MOD_DISP16: begin
                    disp_word  = {disp_hi, disp_lo};
                    disp_bytes = `OFD_BYTES_TWO;
                end
                default: begin
                    disp_word  = `OFD_RST_WORD;
                    disp_bytes = `OFD_BYTES_NONE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> design/ofd_decoder.sv
// Operand field decoder: register, segment, address and immediate decode.
// Function
// - Form 11 makes the operand a register chosen by register field and size.
// - Size 0 picks byte registers, size 1 picks word registers, codes 000-111.
// - Segment field 00 data one, 01 program, 10 stack, 11 data zero.
// - Form 00 no displacement except 16 bits for direct code 110, 01 adds 8 bits, 10 adds 16 bits.
// - Memory codes 000-011 give base/index pairs, 100 si, 101 di, 111 bw; 110 direct at form 00, else bp.
// - Immediate is 16 bits for sign-size pair 01 or 11, else 8 bits.
// - A byte displacement is sign-extended to 16 bits before adding.
// - Displacement is 8 or 16 bits wide, chosen by the addressing form.
// - Short branch target is next address plus signed byte offset.
// - Size bit 0 means byte operation, 1 means word operation.
// - Return with pop count adds the count to the stack pointer.
`timescale 1ns/1ps
`default_nettype none
`include "ofd_cfg.svh"

module ofd_decoder
    import ofd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        DECODE_REQ,
    input  wire logic [1:0]  MODE_FIELD,
    input  wire logic [2:0]  MEM_FIELD,
    input  wire logic [2:0]  REG_FIELD,
    input  wire logic [1:0]  SEG_FIELD,
    input  wire logic        SIZE_BIT,
    input  wire logic        SIGN_BIT,
    input  wire logic [7:0]  DISP_LO,
    input  wire logic [7:0]  DISP_HI,
    input  wire logic [7:0]  BRANCH_OFFSET,
    input  wire logic [15:0] NEXT_PC,
    input  wire logic [15:0] BASE_WORD_VAL,
    input  wire logic [15:0] BASE_POINTER_VAL,
    input  wire logic [15:0] SOURCE_INDEX_VAL,
    input  wire logic [15:0] DESTINATION_INDEX_VAL,
    input  wire logic [15:0] STACK_POINTER_VAL,
    input  wire logic [15:0] POP_COUNT,
    output logic             DECODE_DONE,
    output logic             OPERAND_IS_REG,
    output logic             WORD_OP,
    output logic [3:0]       REG_SEL,
    output logic [1:0]       SEG_SEL,
    output logic             DIRECT_ADDR,
    output logic [1:0]       DISP_BYTES,
    output logic [1:0]       IMM_BYTES,
    output logic [15:0]      EFF_ADDR,
    output logic [15:0]      BRANCH_TARGET,
    output logic [15:0]      POPPED_SP
);

    ////////////////////////////////////////////////////////////////////////
    // Decoded values of the current request.
    ////////////////////////////////////////////////////////////////////////

    ofd_reg_e   dec_reg;
    ofd_seg_e   dec_seg;
    ofd_word_t  dec_base;
    ofd_word_t  dec_index;
    ofd_word_t  dec_ea;
    ofd_word_t  dec_pair;
    ofd_word_t  dec_boff;
    ofd_word_t  dec_branch;
    ofd_word_t  dec_sp;
    ofd_word_t  disp_word;
    logic       dec_is_reg;
    logic       dec_direct;
    logic [1:0] dec_imm;
    logic [1:0] disp_bytes;

    ////////////////////////////////////////////////////////////////////////
    // Output registers and their next values.
    ////////////////////////////////////////////////////////////////////////

    logic       done;
    logic       is_reg;
    logic       word_op;
    ofd_reg_e   reg_sel;
    ofd_seg_e   seg_sel;
    logic       direct;
    logic [1:0] disp_cnt;
    logic [1:0] imm_cnt;
    ofd_word_t  eff_addr;
    ofd_word_t  branch_target;
    ofd_word_t  popped_sp;

    logic       next_done;
    logic       next_is_reg;
    logic       next_word_op;
    ofd_reg_e   next_reg_sel;
    ofd_seg_e   next_seg_sel;
    logic       next_direct;
    logic [1:0] next_disp_cnt;
    logic [1:0] next_imm_cnt;
    ofd_word_t  next_eff_addr;
    ofd_word_t  next_branch_target;
    ofd_word_t  next_popped_sp;

    ////////////////////////////////////////////////////////////////////////
    // Register operand selection.
    ////////////////////////////////////////////////////////////////////////

    assign dec_is_reg = (MODE_FIELD == `OFD_MOD_REGISTER);

    // The size bit forms the top of the selector, so byte and word
    // registers never alias even though they share register codes.
    always_comb begin
        case ({SIZE_BIT, REG_FIELD})
            4'h0:    dec_reg = OFD_ACCUMULATOR_LOW;
            4'h1:    dec_reg = OFD_COUNT_LOW;
            4'h2:    dec_reg = OFD_DATA_LOW;
            4'h3:    dec_reg = OFD_BASE_LOW;
            4'h4:    dec_reg = OFD_ACCUMULATOR_HIGH;
            4'h5:    dec_reg = OFD_COUNT_HIGH;
            4'h6:    dec_reg = OFD_DATA_HIGH;
            4'h7:    dec_reg = OFD_BASE_HIGH;
            4'h8:    dec_reg = OFD_ACCUMULATOR_WORD;
            4'h9:    dec_reg = OFD_COUNT_WORD;
            4'ha:    dec_reg = OFD_DATA_WORD;
            4'hb:    dec_reg = OFD_BASE_WORD;
            4'hc:    dec_reg = OFD_STACK_POINTER;
            4'hd:    dec_reg = OFD_BASE_POINTER;
            4'he:    dec_reg = OFD_SOURCE_INDEX;
            default: dec_reg = OFD_DESTINATION_INDEX;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment selection.
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        case (SEG_FIELD)
            2'h0:    dec_seg = OFD_DATA_SEGMENT_ONE;
            2'h1:    dec_seg = OFD_PROGRAM_SEGMENT;
            2'h2:    dec_seg = OFD_STACK_SEGMENT;
            default: dec_seg = OFD_DATA_SEGMENT_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory operand base, index and displacement.
    ////////////////////////////////////////////////////////////////////////

    // Code 110 with form 00 has no base register at all; the two
    // displacement bytes are then the whole offset.
    assign dec_direct = !dec_is_reg
                        && (MEM_FIELD == `OFD_MEM_DIRECT)
                        && (MODE_FIELD == `OFD_MOD_NODISP);

    always_comb begin
        dec_base  = `OFD_RST_WORD;
        dec_index = `OFD_RST_WORD;
        case (MEM_FIELD)
            `OFD_MEM_BW_SI: begin
                dec_base  = BASE_WORD_VAL;
                dec_index = SOURCE_INDEX_VAL;
            end
            `OFD_MEM_BW_DI: begin
                dec_base  = BASE_WORD_VAL;
                dec_index = DESTINATION_INDEX_VAL;
            end
            `OFD_MEM_BP_SI: begin
                dec_base  = BASE_POINTER_VAL;
                dec_index = SOURCE_INDEX_VAL;
            end
            `OFD_MEM_BP_DI: begin
                dec_base  = BASE_POINTER_VAL;
                dec_index = DESTINATION_INDEX_VAL;
            end
            `OFD_MEM_SI: begin
                dec_base  = SOURCE_INDEX_VAL;
            end
            `OFD_MEM_DI: begin
                dec_base  = DESTINATION_INDEX_VAL;
            end
            `OFD_MEM_DIRECT: begin
                // The direct form has no base; the displacement is the address.
                dec_base  = dec_direct ? `OFD_RST_WORD : BASE_POINTER_VAL;
            end
            default: begin
                dec_base  = BASE_WORD_VAL;
            end
        endcase
    end

    // Register operands reach this path too; their results are masked at capture.
    ofd_disp_ext u_disp_ext (
        .mode_field (MODE_FIELD),
        .direct     (dec_direct),
        .disp_lo    (DISP_LO),
        .disp_hi    (DISP_HI),
        .disp_word  (disp_word),
        .disp_bytes (disp_bytes)
    );

    // Offsets wrap within the 64K segment, so the carry out is dropped.
    // The displacement is added last, after the base and index pair.
    assign dec_pair = dec_base + dec_index;
    assign dec_ea   = dec_pair + disp_word;

    ////////////////////////////////////////////////////////////////////////
    // Immediate width, short branch and stack release.
    ////////////////////////////////////////////////////////////////////////

    // The sign-extend bit never changes the width of the immediate; only
    // the size bit does, so a byte immediate stays one byte either way.
    always_comb begin
        case ({SIGN_BIT, SIZE_BIT})
            `OFD_SW_WORD_A: dec_imm = `OFD_BYTES_TWO;
            `OFD_SW_WORD_B: dec_imm = `OFD_BYTES_TWO;
            default:        dec_imm = `OFD_BYTES_ONE;
        endcase
    end

    // NEXT_PC must already point past the whole branch instruction.
    // The offset is widened first so that a backward branch borrows
    // through the upper byte of the address.
    assign dec_boff   = {{8{BRANCH_OFFSET[`OFD_BYTE_SIGN]}}, BRANCH_OFFSET};
    assign dec_branch = NEXT_PC + dec_boff;

    // A count of 64K and a count of zero both leave the pointer unchanged,
    // because the sum wraps at 16 bits.
    assign dec_sp = STACK_POINTER_VAL + POP_COUNT;

    ////////////////////////////////////////////////////////////////////////
    // Capture on request; results hold until the next request.
    ////////////////////////////////////////////////////////////////////////

    // Outputs other than DECODE_DONE hold between requests, so a consumer that is a cycle late
    // still finds the last decode.
    always_comb begin
        next_done          = DECODE_REQ;
        next_is_reg        = is_reg;
        next_word_op       = word_op;
        next_reg_sel       = reg_sel;
        next_seg_sel       = seg_sel;
        next_direct        = direct;
        next_disp_cnt      = disp_cnt;
        next_imm_cnt       = imm_cnt;
        next_eff_addr      = eff_addr;
        next_branch_target = branch_target;
        next_popped_sp     = popped_sp;
        if (DECODE_REQ) begin
            next_is_reg        = dec_is_reg;
            next_word_op       = SIZE_BIT;
            next_reg_sel       = dec_reg;
            next_seg_sel       = dec_seg;
            next_imm_cnt       = dec_imm;
            next_branch_target = dec_branch;
            next_popped_sp     = dec_sp;
            // A register operand has no address, so its address outputs clear.
            next_direct        = dec_is_reg ? 1'b0 : dec_direct;
            next_disp_cnt      = dec_is_reg ? `OFD_BYTES_NONE : disp_bytes;
            next_eff_addr      = dec_is_reg ? `OFD_RST_WORD : dec_ea;
        end
    end

    // Reset leaves data segment zero selected, the usual default for memory operands.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            done          <= 1'b0;
            is_reg        <= 1'b0;
            word_op       <= 1'b0;
            reg_sel       <= OFD_ACCUMULATOR_LOW;
            seg_sel       <= OFD_DATA_SEGMENT_ZERO;
            direct        <= 1'b0;
            disp_cnt      <= `OFD_RST_BYTES;
            imm_cnt       <= `OFD_RST_BYTES;
            eff_addr      <= `OFD_RST_WORD;
            branch_target <= `OFD_RST_WORD;
            popped_sp     <= `OFD_RST_WORD;
        end else begin
            done          <= next_done;
            is_reg        <= next_is_reg;
            word_op       <= next_word_op;
            reg_sel       <= next_reg_sel;
            seg_sel       <= next_seg_sel;
            direct        <= next_direct;
            disp_cnt      <= next_disp_cnt;
            imm_cnt       <= next_imm_cnt;
            eff_addr      <= next_eff_addr;
            branch_target <= next_branch_target;
            popped_sp     <= next_popped_sp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output ports.
    ////////////////////////////////////////////////////////////////////////

    assign DECODE_DONE    = done;
    assign OPERAND_IS_REG = is_reg;
    assign WORD_OP        = word_op;
    assign REG_SEL        = reg_sel;
    assign SEG_SEL        = seg_sel;
    assign DIRECT_ADDR    = direct;
    assign DISP_BYTES     = disp_cnt;
    assign IMM_BYTES      = imm_cnt;
    assign EFF_ADDR       = eff_addr;
    assign BRANCH_TARGET  = branch_target;
    assign POPPED_SP      = popped_sp;

endmodule
`default_nettype wire

// >>> bench/ofd_regfile_model.sv
// Register file model that feeds base, index and stack values to the decoder.
`timescale 1ns/1ps
`default_nettype none

module ofd_regfile_model #(
    parameter logic [15:0] BW_INIT = 16'h1000,
    parameter logic [15:0] BP_INIT = 16'h2000,
    parameter logic [15:0] SI_INIT = 16'h0010,
    parameter logic [15:0] DI_INIT = 16'h0300,
    parameter logic [15:0] SP_INIT = 16'hfff0
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_sel,
    input  wire logic [15:0] wr_val,
    output logic      [15:0] bw,
    output logic      [15:0] bp,
    output logic      [15:0] si,
    output logic      [15:0] di,
    output logic      [15:0] sp
);
    // Writes land on the clock edge, as a real register file would update them.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {bw, bp, si, di, sp} <= {BW_INIT, BP_INIT, SI_INIT, DI_INIT, SP_INIT};
        end else if (wr_en) begin
            case (wr_sel)
                3'h0: bw <= wr_val;
                3'h1: bp <= wr_val;
                3'h2: si <= wr_val;
                3'h3: di <= wr_val;
                default: sp <= wr_val;
            endcase
        end
    end
endmodule

`default_nettype wire

// >>> bench/ofd_decoder_sva.sv
// Concurrent checks on the operand field decoder ports.
`timescale 1ns/1ps
`default_nettype none

module ofd_decoder_chk (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        DECODE_REQ,
    input wire logic [1:0]  MODE_FIELD,
    input wire logic [2:0]  MEM_FIELD,
    input wire logic [2:0]  REG_FIELD,
    input wire logic [1:0]  SEG_FIELD,
    input wire logic        SIZE_BIT,
    input wire logic [7:0]  DISP_LO,
    input wire logic [7:0]  DISP_HI,
    input wire logic [7:0]  BRANCH_OFFSET,
    input wire logic [15:0] NEXT_PC,
    input wire logic [15:0] STACK_POINTER_VAL,
    input wire logic [15:0] POP_COUNT,
    input wire logic        DECODE_DONE,
    input wire logic        OPERAND_IS_REG,
    input wire logic        WORD_OP,
    input wire logic [3:0]  REG_SEL,
    input wire logic [1:0]  SEG_SEL,
    input wire logic        DIRECT_ADDR,
    input wire logic [1:0]  DISP_BYTES,
    input wire logic [1:0]  IMM_BYTES,
    input wire logic [15:0] EFF_ADDR,
    input wire logic [15:0] BRANCH_TARGET,
    input wire logic [15:0] POPPED_SP
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    done_pulse_a: assert property (!DECODE_REQ |=> !DECODE_DONE && $stable(EFF_ADDR))
        else $error("done or address moved without a request");
    reg_operand_a: assert property (DECODE_REQ && MODE_FIELD == 2'h3 |=>
        OPERAND_IS_REG && EFF_ADDR == 16'h0000 && DISP_BYTES == 2'h0 && !DIRECT_ADDR)
        else $error("register operand decoded wrongly");
    reg_select_a: assert property (DECODE_REQ |=> DECODE_DONE &&
        REG_SEL == {$past(SIZE_BIT), $past(REG_FIELD)} && WORD_OP == $past(SIZE_BIT))
        else $error("register select wrong");
    seg_select_a: assert property (DECODE_REQ |=> SEG_SEL == $past(SEG_FIELD))
        else $error("segment select wrong");
    disp_size_a: assert property (DECODE_REQ && MODE_FIELD != 2'h3 &&
        !(MODE_FIELD == 2'h0 && MEM_FIELD == 3'h6) |=> DISP_BYTES == $past(MODE_FIELD))
        else $error("displacement size wrong");
    direct_addr_a: assert property (DECODE_REQ && MODE_FIELD == 2'h0 &&
        MEM_FIELD == 3'h6 |=> DIRECT_ADDR && DISP_BYTES == 2'h2 &&
        EFF_ADDR == {$past(DISP_HI), $past(DISP_LO)})
        else $error("direct address wrong");
    imm_size_a: assert property (DECODE_REQ |=> IMM_BYTES == ($past(SIZE_BIT) ? 2'h2 : 2'h1))
        else $error("immediate size wrong");
    branch_a: assert property (DECODE_REQ |=> BRANCH_TARGET ==
        $past(NEXT_PC) + {{8{$past(BRANCH_OFFSET[7])}}, $past(BRANCH_OFFSET)})
        else $error("branch target wrong");
    pop_sp_a: assert property (DECODE_REQ |=>
        POPPED_SP == $past(STACK_POINTER_VAL) + $past(POP_COUNT))
        else $error("popped stack pointer wrong");
endmodule

bind ofd_decoder ofd_decoder_chk chk_u (.*);

`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the operand field decoder.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import ofd_pkg::*;
;
    typedef struct {
        logic [1:0]  m;
        logic [2:0]  f;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [15:0] ea;
        logic [1:0]  db;
    } ofd_row_s;

    // Base word 1000, base pointer 2000, source 0010, destination 0300.
    ofd_row_s rows [11] = '{
        '{2'h1, 3'h0, 8'h80, 8'h55, 16'h0f90, 2'h1}, '{2'h2, 3'h1, 8'h34, 8'h12, 16'h2534, 2'h2},
        '{2'h0, 3'h2, 8'haa, 8'hbb, 16'h2010, 2'h0}, '{2'h1, 3'h3, 8'h7f, 8'h00, 16'h237f, 2'h1},
        '{2'h0, 3'h4, 8'h11, 8'h22, 16'h0010, 2'h0}, '{2'h2, 3'h5, 8'h00, 8'h80, 16'h8300, 2'h2},
        '{2'h0, 3'h6, 8'h78, 8'h56, 16'h5678, 2'h2}, '{2'h1, 3'h6, 8'hfe, 8'h00, 16'h1ffe, 2'h1},
        '{2'h2, 3'h7, 8'hff, 8'hff, 16'h0fff, 2'h2}, '{2'h1, 3'h7, 8'h01, 8'h99, 16'h1001, 2'h1},
        '{2'h0, 3'h7, 8'h44, 8'h33, 16'h1000, 2'h0}};

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        req = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [2:0]  mem = 3'h0;
    logic [2:0]  rsel = 3'h0;
    logic [1:0]  seg = 2'h0;
    logic        size = 1'b0;
    logic        sign = 1'b0;
    logic [7:0]  dlo = 8'h00;
    logic [7:0]  dhi = 8'h00;
    logic [7:0]  boff = 8'h00;
    logic [15:0] npc = 16'h0000;
    logic [15:0] pop = 16'h0000;
    logic        wr_en = 1'b0;
    logic [15:0] wr_val = 16'h0000;
    logic [15:0] bw, bp, si, di, sp;
    logic        done, is_reg, word_op, direct;
    logic [3:0]  reg_sel;
    logic [1:0]  seg_sel, disp_b, imm_b;
    logic [15:0] ea, bt, psp;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #2.5 clk = ~clk;

    ofd_regfile_model model_u (.clk(clk), .reset_n(rst_n), .wr_en(wr_en), .wr_sel(3'h4),
        .wr_val(wr_val), .bw(bw), .bp(bp), .si(si), .di(di), .sp(sp));

    ofd_decoder dut_u (.CLK(clk), .RESET_N(rst_n), .DECODE_REQ(req), .MODE_FIELD(mode),
        .MEM_FIELD(mem), .REG_FIELD(rsel), .SEG_FIELD(seg), .SIZE_BIT(size), .SIGN_BIT(sign),
        .DISP_LO(dlo), .DISP_HI(dhi), .BRANCH_OFFSET(boff), .NEXT_PC(npc),
        .BASE_WORD_VAL(bw), .BASE_POINTER_VAL(bp), .SOURCE_INDEX_VAL(si),
        .DESTINATION_INDEX_VAL(di), .STACK_POINTER_VAL(sp), .POP_COUNT(pop),
        .DECODE_DONE(done), .OPERAND_IS_REG(is_reg), .WORD_OP(word_op), .REG_SEL(reg_sel),
        .SEG_SEL(seg_sel), .DIRECT_ADDR(direct), .DISP_BYTES(disp_b), .IMM_BYTES(imm_b),
        .EFF_ADDR(ea), .BRANCH_TARGET(bt), .POPPED_SP(psp));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One request cycle; an idle edge comes first so req never toggles twice at once.
    task automatic go();
        @(posedge clk);
        #1 req = 1'b1;
        @(posedge clk);
        #1 req = 1'b0;
        chk(16'(done), 16'h1);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 chk(ea, 16'h0000);
        chk(bt, 16'h0000);
        chk(psp, 16'h0000);
        chk(16'({done, is_reg, word_op, direct, reg_sel, disp_b, imm_b}), 16'h0000);
        chk(16'(seg_sel), 16'(OFD_DATA_SEGMENT_ZERO));
        rst_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 11; i++) begin
            {mode, mem, dlo, dhi} = {rows[i].m, rows[i].f, rows[i].lo, rows[i].hi};
            go();
            chk(ea, rows[i].ea);
            chk(16'(disp_b), 16'(rows[i].db));
            chk(16'({is_reg, direct}), {15'h0, i == 6});
        end
        $display("test memory forms done");
        for (int k = 0; k < 16; k++) begin
            {mode, rsel, size, sign, seg} = {2'h3, 3'(k), k[3], k[0], k[1:0]};
            go();
            chk(16'({is_reg, word_op, reg_sel}), 16'({1'b1, k[3], 4'(k)}));
            chk(16'({seg_sel, imm_b}), 16'({k[1:0], k[3] ? 2'h2 : 2'h1}));
            chk(ea, 16'h0000);
        end
        $display("test register forms done");
        {npc, boff, pop} = {16'hfff0, 8'h7f, 16'h0010};
        go();
        chk(bt, 16'h006f);
        chk(psp, 16'h0000);
        boff = 8'h80;
        pop = 16'hffff;
        wr_val = 16'h0001;
        wr_en = 1'b1;
        @(posedge clk);
        #1 wr_en = 1'b0;
        go();
        chk(bt, 16'hff70);
        chk(psp, 16'h0000);
        $display("test branch and pop done");
        {mode, rsel, size} = {2'h3, 3'h5, 1'b0};
        @(posedge clk);
        #1 req = 1'b1;
        @(posedge clk);
        #1 chk(16'({done, reg_sel}), 16'h15);
        rsel = 3'h6;
        @(posedge clk);
        #1 req = 1'b0;
        chk(16'({done, reg_sel}), 16'h16);
        @(posedge clk);
        #1 chk(16'({done, reg_sel}), 16'h06);
        $display("test back to back done");
        rst_n = 1'b0;
        #1 chk(16'({ea[3:0], reg_sel, 6'(seg_sel)}), 16'h0003);
        @(posedge clk);
        #1 rst_n = 1'b1;
        go();
        chk(16'({done, reg_sel}), 16'h16);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
